// ==== logic/tick_timer_pkg.sv ====
// Purpose: shared constants for the tick timer block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   byte address is four times the register index
package tick_timer_pkg;

    // ----------------------------------------
    // bus widths
    // ----------------------------------------
    localparam int ADDR_W  = 20;
    localparam int DATA_W  = 32;

    // ----------------------------------------
    // register indices and byte addresses
    // ----------------------------------------
    localparam logic [15:0] PRIO_IDX  = 16'hff20;
    localparam logic [15:0] EN_IDX    = 16'hff22;
    localparam logic [15:0] FLAG_IDX  = 16'hff24;
    localparam logic [15:0] CTRL_IDX  = 16'hff40;
    localparam logic [15:0] COUNT_IDX = 16'hff41;

    localparam logic [ADDR_W-1:0] PRIO_ADDR  = ADDR_W'({PRIO_IDX, 2'b00});
    localparam logic [ADDR_W-1:0] EN_ADDR    = ADDR_W'({EN_IDX, 2'b00});
    localparam logic [ADDR_W-1:0] FLAG_ADDR  = ADDR_W'({FLAG_IDX, 2'b00});
    localparam logic [ADDR_W-1:0] CTRL_ADDR  = ADDR_W'({CTRL_IDX, 2'b00});
    localparam logic [ADDR_W-1:0] COUNT_ADDR = ADDR_W'({COUNT_IDX, 2'b00});

    // ----------------------------------------
    // field layout
    // ----------------------------------------
    localparam int RUN_BIT   = 0;
    localparam int CLEAR_BIT = 1;
    localparam int PRIO_W    = 2;
    localparam int FLAG_NUM  = 4;
    localparam int COUNT_W   = 8;
    // counter stage feeding each source: 1 Hz, 2 Hz, 8 Hz, 32 Hz
    localparam int FLAG_STAGE [0:FLAG_NUM-1] = '{7, 6, 4, 2};

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [COUNT_W-1:0]  COUNT_RST = 8'h00;
    localparam logic [PRIO_W-1:0]   PRIO_RST  = 2'h0;
    localparam logic [FLAG_NUM-1:0] EN_RST    = 4'h0;
    localparam logic [FLAG_NUM-1:0] FLAG_RST  = 4'h0;
    localparam logic                RUN_RST   = 1'b0;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_FREQ_HZ  = 100_000_000;
    localparam int TICK_FREQ_HZ = 256;
    localparam int TICK_CYCLES  = CLK_FREQ_HZ / TICK_FREQ_HZ;
    localparam int DIV_W        = 20;

endpackage

// ==== logic/tick_if.sv ====
// Purpose: carries the 256 Hz tick between prescaler and timer core
// Assumes: single clock domain
// Notes:   tick is a one-cycle pulse
`timescale 1ns/1ps
interface tick_if;
    import tick_timer_pkg::*;

    logic              tick;
    logic [DIV_W-1:0]  divisor;

    modport gen  (input divisor, output tick);
    modport core (output divisor, input tick);
endinterface

// ==== logic/tick_prescaler.sv ====
// Purpose: divides the system clock down to the 256 Hz tick
// Assumes: divisor is at least two
// Notes:   tick marks the falling edge of the 256 Hz signal
`timescale 1ns/1ps
module tick_prescaler (
    // clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_n_i,
    // tick carrier
    tick_if.gen        tk
);
    import tick_timer_pkg::*;

    logic [DIV_W-1:0]  cnt;
    logic [DIV_W-1:0]  next_cnt;
    logic              tick;
    logic              next_tick;

    // ----------------------------------------
    // divider
    // ----------------------------------------
    always_comb begin
        next_tick = 1'b0;
        next_cnt  = cnt + DIV_W'(1);
        if (cnt >= tk.divisor - DIV_W'(1)) begin
            next_cnt  = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end

    assign tk.tick = tick;

endmodule

// ==== logic/tick_timer_irq_control.sv ====
// Purpose: 8-bit time-base counter with four tick interrupt sources
// Assumes: APB slave, zero wait states, CPU mask on the same clock
// Notes:   tick divisor is a parameter so simulation can shorten it
//
// Register access over APB was decided locally.
`timescale 1ns/1ps

module tick_timer_irq_control #(
    parameter int TICK_DIV = tick_timer_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                                  MCLK_I,
    input  wire logic                                  RST_N_I,
    // apb slave
    input  wire logic                                  PSEL_I,
    input  wire logic                                  PENABLE_I,
    input  wire logic                                  PWRITE_I,
    input  wire logic [tick_timer_pkg::ADDR_W-1:0]     PADDR_I,
    input  wire logic [tick_timer_pkg::DATA_W-1:0]     PWDATA_I,
    output logic      [tick_timer_pkg::DATA_W-1:0]     PRDATA_O,
    output logic                                       PREADY_O,
    output logic                                       PSLVERR_O,
    // cpu interrupt side
    input  wire logic [tick_timer_pkg::PRIO_W-1:0]     CPU_MASK_I,
    output logic                                       IRQ_REQ_O,
    output logic      [tick_timer_pkg::PRIO_W-1:0]     IRQ_LEVEL_O,
    // counter state
    output logic      [tick_timer_pkg::COUNT_W-1:0]    COUNT_O
);
    import tick_timer_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [COUNT_W-1:0]   count;
    logic [COUNT_W-1:0]   next_count;
    logic [COUNT_W-1:0]   count_inc;
    logic                 run_req;
    logic                 next_run_req;
    logic                 running;
    logic                 next_running;
    logic [PRIO_W-1:0]    prio;
    logic [PRIO_W-1:0]    next_prio;
    logic [FLAG_NUM-1:0]  irq_en;
    logic [FLAG_NUM-1:0]  next_irq_en;
    logic [FLAG_NUM-1:0]  flags;
    logic [FLAG_NUM-1:0]  next_flags;
    logic [FLAG_NUM-1:0]  flag_set;
    logic [FLAG_NUM-1:0]  flag_clr;
    logic                 irq_req;
    logic                 next_irq_req;
    logic [DATA_W-1:0]    rdata;
    logic [DATA_W-1:0]    next_rdata;
    logic                 slverr;
    logic                 next_slverr;
    logic                 setup;
    logic                 wr_access;
    logic                 wr_prio;
    logic                 wr_en;
    logic                 wr_flag;
    logic                 wr_ctrl;
    logic                 count_step;
    logic                 addr_hit;
    logic                 tick;
    logic                 count_clear;
    logic [COUNT_W-1:0]   count_fall;
    logic [FLAG_NUM-1:0]  flag_pend;
    logic                 flag_any;
    logic                 prio_above;
    logic                 run_state;
    logic                 rd_setup;

    // ----------------------------------------
    // tick source
    // ----------------------------------------
    tick_if tk ();

    assign tk.divisor = DIV_W'(TICK_DIV);
    assign tick       = tk.tick;

    tick_prescaler u_prescaler (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .tk      (tk)
    );

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    assign setup     = PSEL_I & ~PENABLE_I;
    assign wr_access = PSEL_I & PENABLE_I & PWRITE_I;
    assign wr_prio   = wr_access & (PADDR_I == PRIO_ADDR);
    assign wr_en     = wr_access & (PADDR_I == EN_ADDR);
    assign wr_flag   = wr_access & (PADDR_I == FLAG_ADDR);
    assign wr_ctrl   = wr_access & (PADDR_I == CTRL_ADDR);
    assign rd_setup  = setup & ~PWRITE_I;
    assign count_clear = wr_ctrl & PWDATA_I[CLEAR_BIT];

    always_comb begin
        addr_hit = 1'b0;
        case (PADDR_I)
            PRIO_ADDR,
            EN_ADDR,
            FLAG_ADDR,
            CTRL_ADDR,
            COUNT_ADDR: begin
                addr_hit = 1'b1;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // read data, captured in the setup cycle
    // ----------------------------------------
    always_comb begin
        next_rdata  = rdata;
        next_slverr = slverr;
        if (setup) begin
            next_rdata  = '0;
            next_slverr = ~addr_hit;
            if (rd_setup) begin
                case (PADDR_I)
                    PRIO_ADDR: begin
                        next_rdata[PRIO_W-1:0] = prio;
                    end
                    EN_ADDR: begin
                        next_rdata[FLAG_NUM-1:0] = irq_en;
                    end
                    FLAG_ADDR: begin
                        next_rdata[FLAG_NUM-1:0] = flags;
                    end
                    CTRL_ADDR: begin
                        // clear bit always reads zero
                        next_rdata[RUN_BIT]   = run_state;
                        next_rdata[CLEAR_BIT] = 1'b0;
                    end
                    COUNT_ADDR: begin
                        next_rdata[COUNT_W-1:0] = count;
                    end
                    default: begin
                        next_rdata = '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rdata  <= '0;
            slverr <= 1'b0;
        end else begin
            rdata  <= next_rdata;
            slverr <= next_slverr;
        end
    end

    assign PRDATA_O  = rdata;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & slverr;

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_comb begin
        next_prio    = prio;
        next_irq_en  = irq_en;
        next_run_req = run_req;
        if (wr_prio) begin
            next_prio = PWDATA_I[PRIO_W-1:0];
        end
        if (wr_en) begin
            next_irq_en = PWDATA_I[FLAG_NUM-1:0];
        end
        if (wr_ctrl) begin
            next_run_req = PWDATA_I[RUN_BIT];
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            prio    <= PRIO_RST;
            irq_en  <= EN_RST;
            run_req <= RUN_RST;
        end else begin
            prio    <= next_prio;
            irq_en  <= next_irq_en;
            run_req <= next_run_req;
        end
    end

    assign run_state = run_req | running;

    // ----------------------------------------
    // counter
    // ----------------------------------------
    assign count_step = tick & running;
    assign count_inc  = count + COUNT_W'(1);

    always_comb begin
        next_count   = count;
        next_running = running;
        if (tick) begin
            // run state follows the request only on a tick
            next_running = run_req;
            if (running) begin
                next_count = count_inc;
            end
        end
        // count byte itself has no write path
        if (count_clear) begin
            next_count = COUNT_RST;
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            count   <= COUNT_RST;
            running <= RUN_RST;
        end else begin
            count   <= next_count;
            running <= next_running;
        end
    end

    assign COUNT_O = count;

    // ----------------------------------------
    // stage falling edges on an increment
    // ----------------------------------------
    assign count_fall = count & ~count_inc;

    // ----------------------------------------
    // factor flags
    // ----------------------------------------
    for (genvar i = 0; i < FLAG_NUM; i++) begin : g_flag
        // falling edge of the source stage on an increment
        assign flag_set[i] = count_step & ~count_clear
                             & count_fall[FLAG_STAGE[i]];
        assign flag_clr[i] = wr_flag & PWDATA_I[i];
    end

    always_comb begin
        // set wins over a clear in the same cycle
        next_flags = (flags & ~flag_clr) | flag_set;
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            flags <= FLAG_RST;
        end else begin
            flags <= next_flags;
        end
    end

    // ----------------------------------------
    // pending sources
    // ----------------------------------------
    assign flag_pend  = flags & irq_en;
    assign flag_any   = |flag_pend;
    assign prio_above = (prio > CPU_MASK_I);

    // ----------------------------------------
    // interrupt request
    // ----------------------------------------
    always_comb begin
        // mask level held by the cpu
        next_irq_req = flag_any && prio_above;
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= next_irq_req;
        end
    end

    assign IRQ_REQ_O   = irq_req;
    assign IRQ_LEVEL_O = prio;

endmodule

// ==== verif/tick_timer_irq_control_checker.sv ====
// Purpose: port assertions, tick timer
// Assumes: zero wait state apb
// Notes:   bound below
`timescale 1ns/1ps
module tick_timer_irq_control_checker
    import tick_timer_pkg::*;
#(
    parameter int TICK_DIV = 4
) (
    // watched ports
    input wire logic               MCLK_I,
    input wire logic               RST_N_I,
    input wire logic               PSEL_I,
    input wire logic               PENABLE_I,
    input wire logic               PWRITE_I,
    input wire logic [ADDR_W-1:0]  PADDR_I,
    input wire logic [DATA_W-1:0]  PWDATA_I,
    input wire logic [DATA_W-1:0]  PRDATA_O,
    input wire logic               PSLVERR_O,
    input wire logic [PRIO_W-1:0]  CPU_MASK_I,
    input wire logic               IRQ_REQ_O,
    input wire logic [PRIO_W-1:0]  IRQ_LEVEL_O,
    input wire logic [COUNT_W-1:0] COUNT_O
);
    logic              acc;
    logic              mapped;
    logic [PRIO_W-1:0] wprio;
    assign acc = PSEL_I && PENABLE_I;
    assign wprio = PWDATA_I[PRIO_W-1:0];
    assign mapped = PADDR_I inside {PRIO_ADDR, EN_ADDR, FLAG_ADDR, CTRL_ADDR, COUNT_ADDR};
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RST_N_I);
    sequence s_wr(a);
        acc && PWRITE_I && PADDR_I == a;
    endsequence
    sequence s_rd(a);
        PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == a;
    endsequence
    a_count_read: assert property (s_rd(COUNT_ADDR) |=> PRDATA_O == 32'($past(COUNT_O)))
        else $error("count read wrong");
    a_count_ro: assert property (s_wr(COUNT_ADDR) |=> COUNT_O - $past(COUNT_O) <= 8'h01)
        else $error("count written");
    a_count_step: assert property ($changed(COUNT_O) |->
        COUNT_O == 8'h00 || COUNT_O - $past(COUNT_O) == 8'h01) else $error("count jump");
    a_clear_zero: assert property (s_wr(CTRL_ADDR) ##0 PWDATA_I[CLEAR_BIT] |=> !COUNT_O)
        else $error("clear missed");
    a_clear_reads0: assert property (s_rd(CTRL_ADDR) |=> !PRDATA_O[CLEAR_BIT])
        else $error("clear bit read one");
    a_prio_level: assert property (s_wr(PRIO_ADDR) |=> IRQ_LEVEL_O == $past(wprio))
        else $error("level wrong");
    a_irq_cause: assert property (IRQ_REQ_O |-> $past(IRQ_LEVEL_O) > $past(CPU_MASK_I))
        else $error("request not above mask");
    a_err_map: assert property (acc |-> PSLVERR_O == !mapped)
        else $error("error response wrong");
endmodule

bind tick_timer_irq_control tick_timer_irq_control_checker #(.TICK_DIV(TICK_DIV)) chk_u (
    .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PSLVERR_O(PSLVERR_O), .CPU_MASK_I(CPU_MASK_I), .IRQ_REQ_O(IRQ_REQ_O),
    .IRQ_LEVEL_O(IRQ_LEVEL_O), .COUNT_O(COUNT_O));

// ==== verif/cpu_irq_model.sv ====
// Purpose: cpu side of the tick interrupt
// Assumes: accepting raises the mask to the level
// Notes:   ret_i is the exception return
`timescale 1ns/1ps
module cpu_irq_model #(
    parameter int ACK_DELAY = 2
) (
    // clock, reset, device side
    input  wire logic                              clk_i,
    input  wire logic                              rst_n_i,
    input  wire logic                              irq_req_i,
    input  wire logic [tick_timer_pkg::PRIO_W-1:0] irq_level_i,
    input  wire logic                              ret_i,
    output logic      [tick_timer_pkg::PRIO_W-1:0] mask_o
);
    import tick_timer_pkg::*;
    int                wait_cnt;
    int                next_wait_cnt;
    logic [PRIO_W-1:0] next_mask;
    always_comb begin
        next_mask = mask_o;
        next_wait_cnt = irq_req_i ? wait_cnt + 1 : 0;
        if (ret_i)
            next_mask = '0;
        else if (irq_req_i && wait_cnt >= ACK_DELAY)
            next_mask = irq_level_i;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_o <= '0;
            wait_cnt <= 0;
        end else begin
            mask_o <= next_mask;
            wait_cnt <= next_wait_cnt;
        end
    end
endmodule

// ==== verif/tick_timer_irq_control_tb.sv ====
// Purpose: self-checking bench, tick timer
// Assumes: tick divisor cut to 4
// Notes:   irq and count after ticks sampled on the falling edge; cleared count, apb read data and error on the rising edge
`timescale 1ns/1ps
module tick_timer_irq_control_tb;
    import tick_timer_pkg::*;
    localparam int DIV = 4;
    logic               clk = 1'b0, rst_n = 1'b0, ret = 1'b0;
    logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic               pready, pslverr, irq_req, err;
    logic [ADDR_W-1:0]  paddr = '0;
    logic [DATA_W-1:0]  pwdata = '0, prdata, rdata, v;
    logic [PRIO_W-1:0]  mask, level;
    logic [COUNT_W-1:0] count, c0;
    int                 fails = 0, n_checks = 0, k;
    logic [ADDR_W-1:0]  regs [5] = '{PRIO_ADDR, EN_ADDR, FLAG_ADDR, CTRL_ADDR, COUNT_ADDR};

    tick_timer_irq_control #(.TICK_DIV(DIV)) dut_u (
        .MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .CPU_MASK_I(mask),
        .IRQ_REQ_O(irq_req), .IRQ_LEVEL_O(level), .COUNT_O(count));
    cpu_irq_model model_u (.clk_i(clk), .rst_n_i(rst_n), .irq_req_i(irq_req),
        .irq_level_i(level), .ret_i(ret), .mask_o(mask));

    initial forever #5 clk = ~clk;
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report();
    end
    task final_report;
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        for (int n = 0; pready !== 1'b1 && n < 50; n++) @(posedge clk);
        if (pready !== 1'b1)
            chk("pready", 32'h1, 32'(pready));
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task ticks(input int n);
        repeat (n * DIV) @(negedge clk);
    endtask
    // flags raised by n increments from c
    function automatic logic [FLAG_NUM-1:0] falls(logic [COUNT_W-1:0] c, int n);
        logic [FLAG_NUM-1:0] f = '0;
        logic [COUNT_W-1:0]  nx;
        for (int i = 0; i < n; i++) begin
            nx = c + 8'h01;
            for (int j = 0; j < FLAG_NUM; j++)
                if (c[FLAG_STAGE[j]] && !nx[FLAG_STAGE[j]])
                    f[j] = 1'b1;
            c = nx;
        end
        return f;
    endfunction

    initial begin
        void'($urandom(58));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, regs[i], '0);
            chk("reset value", '0, rdata);
        end
        apb(1'b0, PRIO_ADDR + 20'h4, '0);
        chk("unmapped", 32'h1, 32'(err));
        repeat (8) begin
            v = $urandom;
            apb(1'b1, PRIO_ADDR, v);
            apb(1'b1, EN_ADDR, v >> 8);
            apb(1'b0, PRIO_ADDR, '0);
            chk("priority", 32'(v[1:0]), rdata);
            apb(1'b0, EN_ADDR, '0);
            chk("enables", 32'(v[11:8]), rdata);
        end
        apb(1'b1, COUNT_ADDR, 32'hff);
        apb(1'b0, COUNT_ADDR, '0);
        chk("count written", '0, rdata);
        apb(1'b1, CTRL_ADDR, 32'h1);
        apb(1'b0, CTRL_ADDR, '0);
        chk("run bit", 32'h1, rdata);
        c0 = count;
        for (k = 0; count === c0 && k < 50; k++) @(negedge clk);
        c0 = count;
        k = 1 + $urandom % 20;
        ticks(k);
        chk("count step", 32'(c0 + 8'(k)), 32'(count));
        apb(1'b1, CTRL_ADDR, '0);
        ticks(2);
        c0 = count;
        apb(1'b0, CTRL_ADDR, '0);
        chk("run bit", '0, rdata);
        ticks(5);
        chk("count held", 32'(c0), 32'(count));
        apb(1'b1, CTRL_ADDR, 32'h1);
        for (k = 0; count === c0 && k < 50; k++) @(negedge clk);
        chk("count resumed", 32'(c0 + 8'h01), 32'(count));
        apb(1'b1, CTRL_ADDR, '0);
        ticks(2);
        apb(1'b1, CTRL_ADDR, 32'h2);
        ticks(3);
        apb(1'b0, CTRL_ADDR, '0);
        chk("clear bit", '0, rdata);
        chk("cleared count", '0, 32'(count));
        apb(1'b1, FLAG_ADDR, 32'hf);
        k = 40 + $urandom % 200;
        apb(1'b1, CTRL_ADDR, 32'h1);
        ticks(k);
        apb(1'b1, CTRL_ADDR, '0);
        ticks(2);
        apb(1'b0, FLAG_ADDR, '0);
        chk("flags", 32'(falls(8'h00, int'(count))), rdata);
        v = $urandom;
        apb(1'b1, FLAG_ADDR, v);
        apb(1'b0, FLAG_ADDR, '0);
        chk("flags w1c", 32'(falls(8'h00, int'(count)) & ~v[3:0]), rdata);
        apb(1'b1, FLAG_ADDR, 32'hf);
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        apb(1'b1, EN_ADDR, 32'h8);
        apb(1'b1, PRIO_ADDR, 32'h2);
        apb(1'b1, CTRL_ADDR, 32'h3);
        for (k = 0; irq_req !== 1'b1 && k < 200; k++) @(negedge clk);
        chk("irq raised", 32'h1, 32'(irq_req));
        repeat (6) @(negedge clk);
        chk("irq masked", '0, 32'(irq_req));
        final_report();
    end
endmodule
